// ==== budget_isolation_pkg.sv ====
package budget_isolation_pkg;

	// ======================================================================
	// register offsets (byte addresses in configuration space)
	localparam logic [11:0] OFFSET_BUDGET_DATA = 12'h214;
	localparam logic [11:0] OFFSET_BUDGET_FLAGS = 12'h218;
	localparam logic [11:0] OFFSET_ISOLATION_HEADER = 12'h220;
	localparam logic [11:0] OFFSET_ISOLATION_CONTROL = 12'h224;

	// ======================================================================
	// budgeting data word fields and reset values
	localparam int BASE_POWER_LSB = 0;
	localparam int DATA_SCALE_LSB = 8;
	localparam int SUBSTATE_LSB = 10;
	localparam int POWER_STATE_FIELD_LSB = 13;
	localparam int COND_TYPE_LSB = 15;
	localparam int POWER_RAIL_LSB = 18;
	localparam logic [7:0] BASE_POWER_RESET = 8'h04;
	localparam logic [1:0] DATA_SCALE_RESET = 2'h0;
	localparam logic [2:0] SUBSTATE_RESET = 3'h0;
	localparam logic [1:0] POWER_STATE_FIELD_D0 = 2'h0;
	localparam logic [2:0] COND_TYPE_MAXIMUM = 3'h7;
	localparam logic [2:0] COND_TYPE_SUSTAINED = 3'h1;
	localparam logic [2:0] POWER_RAIL_RESET = 3'h2;
	localparam logic [7:0] SELECT_D0_MAXIMUM = 8'h00;
	localparam logic [7:0] SELECT_D0_SUSTAINED = 8'h01;

	// ======================================================================
	// budget capability word
	localparam int SYSTEM_ALLOCATED_BIT = 0;
	localparam logic SYSTEM_ALLOCATED_RESET = 1'b0;

	// ======================================================================
	// isolation capability header
	localparam logic [15:0] ISOLATION_CAP_ID = 16'h000D;
	localparam logic [3:0] ISOLATION_CAP_VERSION = 4'h1;
	localparam logic [11:0] ISOLATION_NEXT_CAP = 12'h000;

	// ======================================================================
	// isolation capability/control fields
	localparam int ISOLATION_FEATURES = 7;
	localparam logic [6:0] ISOLATION_SUPPORT = 7'h7F;
	localparam logic [7:0] EGRESS_VECTOR_SIZE = 8'h08;
	localparam int EGRESS_SIZE_LSB = 8;
	localparam int ENABLE_LSB = 16;
	localparam logic [6:0] ENABLE_RESET = 7'h00;
	localparam int ENABLE_BYTE_LANE = 2;
	localparam int EGRESS_ENABLE_INDEX = 5;

	// ======================================================================
	// grouped carriers
	typedef struct packed {
		logic [2:0] power_rail;
		logic [2:0] cond_type;
		logic [1:0] power_state_field;
		logic [2:0] power_substate_field;
		logic [1:0] data_scale;
		logic [7:0] base_power;
	} budget_fields_type;

	typedef struct packed {
		logic valid;
		logic [7:0] base_power;
		logic system_allocated;
	} eeprom_load_type;

	typedef struct packed {
		logic read;
		logic write;
		logic [11:0] addr;
		logic [3:0] byte_en;
		logic [31:0] wdata;
	} cfg_request_type;

	// access phase of the configuration port
	typedef enum logic [1:0] {
		PORT_IDLE,
		PORT_READ,
		PORT_WRITE
	} port_phase_type;

endpackage

// ==== budget_isolation_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - base power bits 7:0, reset 04h, loadable
// - data scale bits 9:8, reset 00b
// - power substate bits 12:10, reset 000b
// - power state bits 14:13, D0 = 00b
// - condition type bits 17:15, maximum = 111b
// - supply rail bits 20:18, reset 010b
// - system allocated bit 0, reset 0, loadable
// - isolation header id 000Dh in 15:0
// - isolation header version 1h in 19:16
// - next capability pointer 000h in 31:20
// - isolation registers exist on downstream ports only
// - capability bits 6:0 read as ones
// - egress vector size 15:8 reads 08h
// - bit 16 source validation enable, reset 0
// - bit 17 translation blocking enable, reset 0
// - bit 18 request redirect enable, reset 0
// - bit 19 completion redirect enable, reset 0
// - bit 20 upstream forwarding enable, reset 0
// - bit 21 egress control enable, reset 0
// - bit 22 direct translated enable, reset 0
// - selector 00h max, 01h sustained, else zero
// - egress-blocked target with enable blocks peer request
module budget_isolation_regs
	import budget_isolation_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// port strap: high on a downstream port
	input wire logic downstream_strap,
	// configuration access port
	input wire cfg_request_type cfg_req,
	output logic [31:0] cfg_rdata,
	output logic cfg_rd_done,
	output logic cfg_wr_done,
	// budgeting data selector index
	input wire logic [7:0] data_select,
	// defaults loaded from the serial eeprom
	input wire eeprom_load_type eeprom_load,
	// egress control vector and peer request check
	input wire logic [7:0] egress_vector,
	input wire logic p2p_req_valid,
	input wire logic [2:0] p2p_req_target,
	output logic p2p_req_blocked,
	// feature enables toward the forwarding logic
	output logic [6:0] isolation_enables,
	output logic is_downstream
);

	// ======================================================================
	// helpers

	// address decode shared by read and write paths
	function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] offset);
		addr_hit = (addr[11:2] == offset[11:2]);
	endfunction

	// pack the budgeting fields into a word, reserved bits zero
	function automatic logic [31:0] budget_word(input budget_fields_type f);
		logic [31:0] w;
		w = 32'h00000000;
		w[BASE_POWER_LSB +: 8] = f.base_power;
		w[DATA_SCALE_LSB +: 2] = f.data_scale;
		w[SUBSTATE_LSB +: 3] = f.power_substate_field;
		w[POWER_STATE_FIELD_LSB +: 2] = f.power_state_field;
		w[COND_TYPE_LSB +: 3] = f.cond_type;
		w[POWER_RAIL_LSB +: 3] = f.power_rail;
		budget_word = w;
	endfunction

	// ======================================================================
	// strap capture

	logic strap_taken_reg;
	logic strap_taken_next;
	logic downstream_reg;
	logic downstream_next;

	// the strap is caught once, on the first edge after reset release
	always_comb begin
		strap_taken_next = 1'b1;
		downstream_next = downstream_reg;
		if (!strap_taken_reg) begin
			downstream_next = downstream_strap;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			strap_taken_reg <= 1'b0;
			downstream_reg <= 1'b0;
		end else begin
			strap_taken_reg <= strap_taken_next;
			downstream_reg <= downstream_next;
		end
	end

	// ======================================================================
	// eeprom-loadable read-only defaults

	logic [7:0] base_power_reg;
	logic [7:0] base_power_next;
	logic system_allocated_reg;
	logic system_allocated_next;

	// only the eeprom loader may change these; configuration writes cannot
	always_comb begin
		base_power_next = base_power_reg;
		system_allocated_next = system_allocated_reg;
		if (eeprom_load.valid) begin
			base_power_next = eeprom_load.base_power;
			system_allocated_next = eeprom_load.system_allocated;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			base_power_reg <= BASE_POWER_RESET;
			system_allocated_reg <= SYSTEM_ALLOCATED_RESET;
		end else begin
			base_power_reg <= base_power_next;
			system_allocated_reg <= system_allocated_next;
		end
	end

	// ======================================================================
	// budgeting data word as seen through the selector

	budget_fields_type budget_fields;
	logic [31:0] budget_data_word;

	// fixed fields of the described operating condition
	always_comb begin
		budget_fields.base_power = base_power_reg;
		budget_fields.data_scale = DATA_SCALE_RESET;
		budget_fields.power_substate_field = SUBSTATE_RESET;
		budget_fields.power_state_field = POWER_STATE_FIELD_D0;
		budget_fields.cond_type = COND_TYPE_MAXIMUM;
		budget_fields.power_rail = POWER_RAIL_RESET;
		if (data_select == SELECT_D0_SUSTAINED) begin
			budget_fields.cond_type = COND_TYPE_SUSTAINED;
		end
	end

	// unsupported selector values report a zero budget
	always_comb begin
		if (data_select == SELECT_D0_MAXIMUM || data_select == SELECT_D0_SUSTAINED) begin
			budget_data_word = budget_word(budget_fields);
		end else begin
			budget_data_word = 32'h00000000;
		end
	end

	// ======================================================================
	// isolation enables

	logic [6:0] enable_reg;
	logic [6:0] enable_next;
	logic enable_write;

	// enables sit in byte lane 2; only a downstream port accepts them; a read wins
	assign enable_write = cfg_req.write && !cfg_req.read && cfg_req.byte_en[ENABLE_BYTE_LANE]
		&& downstream_reg && addr_hit(cfg_req.addr, OFFSET_ISOLATION_CONTROL);

	// bits 16..22 are plain read-write; bit 23 and up are dropped
	always_comb begin
		enable_next = enable_reg;
		if (enable_write) begin
			enable_next[0] = cfg_req.wdata[ENABLE_LSB + 0];
			enable_next[1] = cfg_req.wdata[ENABLE_LSB + 1];
			enable_next[2] = cfg_req.wdata[ENABLE_LSB + 2];
			enable_next[3] = cfg_req.wdata[ENABLE_LSB + 3];
			enable_next[4] = cfg_req.wdata[ENABLE_LSB + 4];
			enable_next[5] = cfg_req.wdata[ENABLE_LSB + 5];
			enable_next[6] = cfg_req.wdata[ENABLE_LSB + 6];
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			enable_reg <= ENABLE_RESET;
		end else begin
			enable_reg <= enable_next;
		end
	end

	// ======================================================================
	// read-back words of the isolation capability

	logic [31:0] isolation_header_word;
	logic [31:0] isolation_control_word;

	// header and control read as zero on the upstream port
	always_comb begin
		isolation_header_word = 32'h00000000;
		isolation_control_word = 32'h00000000;
		if (downstream_reg) begin
			isolation_header_word[15:0] = ISOLATION_CAP_ID;
			isolation_header_word[19:16] = ISOLATION_CAP_VERSION;
			isolation_header_word[31:20] = ISOLATION_NEXT_CAP;
			isolation_control_word[ISOLATION_FEATURES-1:0] = ISOLATION_SUPPORT;
			isolation_control_word[EGRESS_SIZE_LSB +: 8] = EGRESS_VECTOR_SIZE;
			isolation_control_word[ENABLE_LSB + 0] = enable_reg[0];
			isolation_control_word[ENABLE_LSB + 1] = enable_reg[1];
			isolation_control_word[ENABLE_LSB + 2] = enable_reg[2];
			isolation_control_word[ENABLE_LSB + 3] = enable_reg[3];
			isolation_control_word[ENABLE_LSB + 4] = enable_reg[4];
			isolation_control_word[ENABLE_LSB + 5] = enable_reg[5];
			isolation_control_word[ENABLE_LSB + 6] = enable_reg[6];
		end
	end

	// ======================================================================
	// read-back of the capability word and the read mux

	logic [31:0] flags_word;
	logic [31:0] read_word;

	// capability word: only the system allocated bit is implemented
	always_comb begin
		flags_word = 32'h00000000;
		flags_word[SYSTEM_ALLOCATED_BIT] = system_allocated_reg;
	end

	// word picked by the dword address; unmapped and reserved space answers zero
	always_comb begin
		read_word = 32'h00000000;
		if (addr_hit(cfg_req.addr, OFFSET_BUDGET_DATA)) begin
			read_word = budget_data_word;
		end else if (addr_hit(cfg_req.addr, OFFSET_BUDGET_FLAGS)) begin
			read_word = flags_word;
		end else if (addr_hit(cfg_req.addr, OFFSET_ISOLATION_HEADER)) begin
			read_word = isolation_header_word;
		end else if (addr_hit(cfg_req.addr, OFFSET_ISOLATION_CONTROL)) begin
			read_word = isolation_control_word;
		end
	end

	// ======================================================================
	// configuration port: one-cycle answer to each request

	port_phase_type phase_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;

	// a read latches the picked word and wins over a write
	always_comb begin
		phase_next = PORT_IDLE;
		rdata_next = rdata_reg;
		if (cfg_req.read) begin
			phase_next = PORT_READ;
			rdata_next = read_word;
		end else if (cfg_req.write) begin
			phase_next = PORT_WRITE;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rdata_reg <= 32'h00000000;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// done strobes decoded from the phase of the request being taken
	logic rd_done_reg;
	logic wr_done_reg;
	logic rd_done_next;
	logic wr_done_next;

	always_comb begin
		case (phase_next)
			PORT_READ: begin
				rd_done_next = 1'b1;
				wr_done_next = 1'b0;
			end
			PORT_WRITE: begin
				rd_done_next = 1'b0;
				wr_done_next = 1'b1;
			end
			default: begin
				rd_done_next = 1'b0;
				wr_done_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rd_done_reg <= 1'b0;
			wr_done_reg <= 1'b0;
		end else begin
			rd_done_reg <= rd_done_next;
			wr_done_reg <= wr_done_next;
		end
	end

	// ======================================================================
	// peer request egress check

	logic blocked_reg;
	logic blocked_next;
	logic egress_active;
	logic target_listed;

	// egress control acts only on a downstream port with its enable set
	assign egress_active = downstream_reg && enable_reg[EGRESS_ENABLE_INDEX];
	assign target_listed = egress_vector[p2p_req_target];

	// a set vector bit blocks the target only while egress control is on
	always_comb begin
		blocked_next = p2p_req_valid && egress_active && target_listed;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			blocked_reg <= 1'b0;
		end else begin
			blocked_reg <= blocked_next;
		end
	end

	// ======================================================================
	// outputs, all straight from flip-flops

	// configuration port
	assign cfg_rdata = rdata_reg;
	assign cfg_rd_done = rd_done_reg;
	assign cfg_wr_done = wr_done_reg;

	// forwarding side
	assign p2p_req_blocked = blocked_reg;
	assign isolation_enables = enable_reg;
	assign is_downstream = downstream_reg;

endmodule
`default_nettype wire

// ==== budget_isolation_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// port checker for the budget and isolation register bank
module budget_isolation_monitor
	import budget_isolation_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// configuration port
	input wire cfg_request_type cfg_req,
	input wire logic [31:0] cfg_rdata,
	input wire logic [7:0] data_select,
	// forwarding side
	input wire logic [7:0] egress_vector,
	input wire logic p2p_req_valid,
	input wire logic [2:0] p2p_req_target,
	input wire logic p2p_req_blocked,
	input wire logic [6:0] isolation_enables,
	input wire logic is_downstream
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	// address decode of the request being taken
	logic rd_hdr;
	logic rd_ctl;
	logic rd_data;
	logic rd_flags;
	logic wr_ctl;
	assign rd_hdr = cfg_req.read && cfg_req.addr[11:2] == OFFSET_ISOLATION_HEADER[11:2];
	assign rd_ctl = cfg_req.read && cfg_req.addr[11:2] == OFFSET_ISOLATION_CONTROL[11:2];
	assign rd_data = cfg_req.read && cfg_req.addr[11:2] == OFFSET_BUDGET_DATA[11:2];
	assign rd_flags = cfg_req.read && cfg_req.addr[11:2] == OFFSET_BUDGET_FLAGS[11:2];
	assign wr_ctl = cfg_req.write && !cfg_req.read && cfg_req.byte_en[2]
		&& cfg_req.addr[11:2] == OFFSET_ISOLATION_CONTROL[11:2];

	hdr_value_a: assert property (rd_hdr && is_downstream |=> cfg_rdata == 32'h0001000D)
		else $error("isolation header value wrong");
	cap_fields_a: assert property (rd_ctl && is_downstream |=>
		cfg_rdata[15:0] == 16'h087F && cfg_rdata[31:23] == 9'h000)
		else $error("capability fields wrong");
	enable_read_a: assert property (rd_ctl && is_downstream |=>
		cfg_rdata[22:16] == $past(isolation_enables))
		else $error("enable readback differs from enables");
	upstream_zero_a: assert property ((rd_hdr || rd_ctl) && !is_downstream |=>
		cfg_rdata == 32'h00000000)
		else $error("isolation space visible on upstream port");
	upstream_off_a: assert property (!is_downstream |-> isolation_enables == 7'h00)
		else $error("enables set on upstream port");
	enable_hold_a: assert property (!wr_ctl |=> $stable(isolation_enables))
		else $error("enables changed without a write");
	enable_write_a: assert property (wr_ctl && is_downstream |=>
		isolation_enables == $past(cfg_req.wdata[22:16]))
		else $error("enables do not follow written value");
	budget_word_a: assert property (rd_data && data_select == 8'h00 |=>
		cfg_rdata[31:8] == 24'h000B80)
		else $error("budget word fields wrong");
	flags_rsvd_a: assert property (rd_flags |=> cfg_rdata[31:1] == 31'h00000000)
		else $error("capability word reserved bits set");
	p2p_block_a: assert property (1'b1 |=> p2p_req_blocked == $past(p2p_req_valid
		&& is_downstream && isolation_enables[5] && egress_vector[p2p_req_target]))
		else $error("peer request block decision wrong");
endmodule

bind budget_isolation_regs budget_isolation_monitor monitor_inst (
	.clock(clock),
	.nrst(nrst),
	.cfg_req(cfg_req),
	.cfg_rdata(cfg_rdata),
	.data_select(data_select),
	.egress_vector(egress_vector),
	.p2p_req_valid(p2p_req_valid),
	.p2p_req_target(p2p_req_target),
	.p2p_req_blocked(p2p_req_blocked),
	.isolation_enables(isolation_enables),
	.is_downstream(is_downstream)
);
`default_nettype wire

// ==== power_budget_acs_cap_regs_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// register bank testbench
module power_budget_acs_cap_regs_tb
	import budget_isolation_pkg::*;
;
	logic clock, nrst, downstream_strap, p2p_req_valid;
	cfg_request_type cfg_req;
	eeprom_load_type eeprom_load;
	logic [7:0] data_select, egress_vector;
	logic [2:0] p2p_req_target;
	logic [31:0] cfg_rdata;
	logic cfg_rd_done, cfg_wr_done, p2p_req_blocked, is_downstream;
	logic [6:0] isolation_enables;
	int n_mismatch, check_count, i;

	budget_isolation_regs DUT (.clock(clock), .nrst(nrst), .downstream_strap(downstream_strap),
		.cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rd_done(cfg_rd_done),
		.cfg_wr_done(cfg_wr_done), .data_select(data_select), .eeprom_load(eeprom_load),
		.egress_vector(egress_vector), .p2p_req_valid(p2p_req_valid),
		.p2p_req_target(p2p_req_target), .p2p_req_blocked(p2p_req_blocked),
		.isolation_enables(isolation_enables), .is_downstream(is_downstream));

	// 125 MHz clock
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// ==========================================================
	// helpers
	task test_done;
		$display("checks=%0d mismatches=%0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one request, then a bounded wait for its answer strobe
	task cfg_access(input logic rd, input logic [11:0] addr, input logic [3:0] be,
		input logic [31:0] wd);
		int k;
		@(posedge clock);
		cfg_req <= '{rd, !rd, addr, be, wd};
		@(posedge clock);
		cfg_req <= '0;
		#1;
		for (k = 0; k < 4 && (rd ? cfg_rd_done : cfg_wr_done) !== 1'b1; k++) @(posedge clock) #1;
		if (k == 4) begin
			check(32'h0, 32'h1);
			test_done;
		end
	endtask

	task cfg_read(input logic [11:0] addr, input logic [31:0] exp);
		cfg_access(1'b1, addr, 4'hF, 32'h00000000);
		check(cfg_rdata, exp);
	endtask

	task cfg_write(input logic [11:0] addr, input logic [3:0] be, input logic [31:0] wd);
		cfg_access(1'b0, addr, be, wd);
	endtask

	task p2p(input logic [2:0] tgt, input logic exp);
		@(posedge clock);
		p2p_req_valid <= 1'b1;
		p2p_req_target <= tgt;
		@(posedge clock);
		p2p_req_valid <= 1'b0;
		#1;
		check({31'h0, p2p_req_blocked}, {31'h0, exp});
	endtask

	task do_reset(input logic strap);
		@(posedge clock);
		nrst <= 1'b0;
		downstream_strap <= strap;
		repeat (3) @(posedge clock);
		nrst <= 1'b1;
		repeat (2) @(posedge clock);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		nrst = 1'b0;
		downstream_strap = 1'b1;
		cfg_req = '0;
		eeprom_load = '0;
		data_select = 8'h00;
		egress_vector = 8'h00;
		p2p_req_valid = 1'b0;
		p2p_req_target = 3'h0;
		n_mismatch = 0;
		check_count = 0;
		do_reset(1'b1);
		check({31'h0, is_downstream}, 32'h1);
		cfg_read(12'h214, 32'h000B8004);
		@(posedge clock) data_select <= 8'h01;
		cfg_read(12'h214, 32'h00088004);
		@(posedge clock) data_select <= 8'h02;
		cfg_read(12'h214, 32'h00000000);
		@(posedge clock) data_select <= 8'h00;
		cfg_read(12'h218, 32'h00000000);
		cfg_read(12'h220, 32'h0001000D);
		cfg_read(12'h224, 32'h0000087F);
		cfg_read(12'h200, 32'h00000000);
		$display("test reset values done");
		// writes to read-only words and a write without lane 2
		cfg_write(12'h214, 4'hF, 32'hFFFFFFFF);
		cfg_write(12'h218, 4'hF, 32'hFFFFFFFF);
		cfg_write(12'h220, 4'hF, 32'hFFFFFFFF);
		cfg_write(12'h224, 4'hB, 32'hFFFFFFFF);
		cfg_read(12'h214, 32'h000B8004);
		cfg_read(12'h218, 32'h00000000);
		cfg_read(12'h220, 32'h0001000D);
		cfg_read(12'h224, 32'h0000087F);
		$display("test read-only writes done");
		// each enable alone, then all bits written
		for (i = 0; i < 7; i++) begin
			cfg_write(12'h224, 4'h4, 32'h1 << (16 + i));
			check({25'h0, isolation_enables}, 32'h1 << i);
			cfg_read(12'h224, 32'h0000087F | (32'h1 << (16 + i)));
		end
		cfg_write(12'h224, 4'hF, 32'hFFFFFFFF);
		cfg_read(12'h224, 32'h007F087F);
		$display("test enables done");
		// peer request blocking by vector and enable
		@(posedge clock) egress_vector <= 8'h08;
		p2p(3'h3, 1'b1);
		p2p(3'h2, 1'b0);
		cfg_write(12'h224, 4'h4, 32'h005F0000);
		p2p(3'h3, 1'b0);
		$display("test egress done");
		// serial eeprom override of defaults
		@(posedge clock) eeprom_load <= '{1'b1, 8'h12, 1'b1};
		@(posedge clock) eeprom_load <= '0;
		cfg_read(12'h214, 32'h000B8012);
		cfg_read(12'h218, 32'h00000001);
		$display("test eeprom done");
		// upstream port hides the isolation words
		do_reset(1'b0);
		check({31'h0, is_downstream}, 32'h0);
		cfg_read(12'h220, 32'h00000000);
		cfg_write(12'h224, 4'hF, 32'hFFFFFFFF);
		cfg_read(12'h224, 32'h00000000);
		check({25'h0, isolation_enables}, 32'h0);
		p2p(3'h3, 1'b0);
		cfg_read(12'h214, 32'h000B8004);
		$display("test upstream done");
		test_done;
	end
endmodule
`default_nettype wire
